//--- shared/lsw_pkg.sv
package lsw_pkg;

  // Clock rate
  localparam int CLK_MHZ = 100;

  // Times in microseconds, and their cycle counts
  localparam int T_HOLD_NORMAL_US = 150;
  localparam int T_HOLD_SHORT_US  = 2;
  localparam int T_OVERSHOOT_US   = 6;
  localparam int T_SETTLE_FP_US   = 2;
  localparam int T_SETTLE_NORM_US = 150;
  localparam int HOLD_NORMAL_CYC  = T_HOLD_NORMAL_US * CLK_MHZ;
  localparam int HOLD_SHORT_CYC   = T_HOLD_SHORT_US * CLK_MHZ;
  localparam int OVERSHOOT_CYC    = T_OVERSHOOT_US * CLK_MHZ;
  localparam int SETTLE_FP_CYC    = T_SETTLE_FP_US * CLK_MHZ;
  localparam int SETTLE_NORM_CYC  = T_SETTLE_NORM_US * CLK_MHZ;

  localparam int CNT_W = 16;

  // Register byte offsets
  localparam logic [7:0] OFS_SUPV_CTRL  = 8'h00;
  localparam logic [7:0] OFS_CLK_DIV    = 8'h04;
  localparam logic [7:0] OFS_CLK_REQ    = 8'h08;
  localparam logic [7:0] OFS_CORE_LEVEL = 8'h0C;
  localparam logic [7:0] OFS_OSC_FREQ   = 8'h10;
  localparam logic [7:0] OFS_STATUS     = 8'h14;

  // Field positions
  localparam int SUP_EN_BIT  = 0;
  localparam int SUP_FP_BIT  = 1;
  localparam int MON_EN_BIT  = 2;
  localparam int MON_FP_BIT  = 3;
  localparam int REQ_EN_BIT  = 0;
  localparam int SRC_XT2_BIT = 1;
  localparam int ST_HOLD_BIT = 0;
  localparam int ST_OVS_BIT  = 1;
  localparam int ST_SET_BIT  = 2;
  localparam int ST_EXP_BIT  = 3;
  localparam int ST_RST_BIT  = 4;

  // Reset values
  localparam logic [3:0]  SUPV_RESET  = 4'h5;
  localparam logic [2:0]  DIV_RESET   = 3'h0;
  localparam logic [1:0]  REQ_RESET   = 2'h1;
  localparam logic [1:0]  LEVEL_RESET = 2'h0;
  localparam logic [15:0] FREQ_RESET  = 16'h0000;

  // Divide-by-two code of the main clock divider
  localparam logic [2:0] DIV_BY_TWO = 3'h1;

  // Overspeed thresholds in kHz per core level 0..3
  localparam logic [15:0] THR_L0_KHZ = 16'h1388;
  localparam logic [15:0] THR_L1_KHZ = 16'h1D4C;
  localparam logic [15:0] THR_L2_KHZ = 16'h2710;
  localparam logic [15:0] THR_L3_KHZ = 16'h30D4;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    ST_RUN   = 3'b001,
    ST_SLEEP = 3'b010,
    ST_HOLD  = 3'b100
  } lsw_state_t;

endpackage : lsw_pkg

//--- design/lsw_timer.sv
`timescale 1ns/100ps
module lsw_timer
  import lsw_pkg::*;
(
  // Clock and reset
  input  wire logic             mclk_i,
  input  wire logic             resetn_i,
  // Control
  input  wire logic             load_i,
  input  wire logic [CNT_W-1:0] value_i,
  // Status
  output logic                  busy_o,
  output logic                  done_o
);

  logic [CNT_W-1:0] cnt_q;

  always_ff @(posedge mclk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      cnt_q <= '0;
    else if (load_i)
      cnt_q <= value_i;
    else if (cnt_q != '0)
      cnt_q <= cnt_q - 1'b1;
  end

  assign busy_o = (cnt_q != '0);
  assign done_o = (cnt_q == {{(CNT_W-1){1'b0}}, 1'b1}) && !load_i;

endmodule : lsw_timer

//--- design/lsw_wake_ctrl.sv
// The register offsets and the AXI4-Lite register port were decided locally.
`timescale 1ns/100ps
// Function
// - Normal supervision masks CPU execution 150 us after deep-sleep wake.
// - Both disabled or both full-performance shortens the mask to 2 us.
// - Short mask risks overspeed only above level threshold on internal oscillator.
// - Oscillator may overshoot up to 6 us after deep-sleep wake.
// - Peripheral clock from internal oscillator is not gated during wake-up.
// - Full-performance supervisor applies about 2 us settling delay after change.
// - Raising core level in full-performance mode expires early and resets device.
module lsw_wake_ctrl
  import lsw_pkg::*;
#(
  parameter int HOLD_NORMAL_CYCLES = HOLD_NORMAL_CYC,
  parameter int SETTLE_NORM_CYCLES = SETTLE_NORM_CYC
)
(
  // Clock and reset
  input  wire logic        mclk_i,
  input  wire logic        resetn_i,
  // AXI4-Lite write address and data
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // AXI4-Lite read
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Power state events
  input  wire logic        sleep_enter_i,
  input  wire logic        wake_i,
  input  wire logic        mclk_from_osc_i,
  input  wire logic        vcore_settled_i,
  // Clock and reset control
  output logic             cpu_clk_en_o,
  output logic             periph_clk_en_o,
  output logic             periph_src_xt2_o,
  output logic [2:0]       main_clock_divider_o,
  output logic [1:0]       core_level_o,
  output logic             osc_overshoot_o,
  output logic             supv_reset_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Registers and state
  lsw_state_t  state_q;
  logic [3:0]  supv_q;
  logic [2:0]  div_q;
  logic [1:0]  req_q;
  logic [1:0]  level_q;
  logic [15:0] freq_q;
  logic        rst_evt_q;
  logic        reset_pulse_q;
  logic        aw_have_q;
  logic        w_have_q;
  logic [7:0]  awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0]  wstrb_q;
  logic        bvalid_q;
  logic [1:0]  bresp_q;
  logic        rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0]  rresp_q;

  logic        hold_busy;
  logic        hold_done;
  logic        ovs_busy;
  logic        set_busy;
  logic        set_done;
  logic        short_mask;
  logic        wr_fire;
  logic        level_raise;
  logic        overspeed;
  logic [15:0] thr_khz;
  logic [CNT_W-1:0] hold_load;
  logic [CNT_W-1:0] set_load;
  logic [31:0] status;

  function automatic logic mapped(input logic [7:0] a);
    mapped = (a == OFS_SUPV_CTRL) || (a == OFS_CLK_DIV) || (a == OFS_CLK_REQ) ||
             (a == OFS_CORE_LEVEL) || (a == OFS_OSC_FREQ) || (a == OFS_STATUS);
  endfunction : mapped

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite write path
  assign s_axi_awready = !aw_have_q && !bvalid_q;
  assign s_axi_wready  = !w_have_q && !bvalid_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;
  assign wr_fire       = aw_have_q && w_have_q && !bvalid_q;

  always_ff @(posedge mclk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      aw_have_q <= 1'b0;
      w_have_q  <= 1'b0;
      awaddr_q  <= 8'h00;
      wdata_q   <= 32'h0000_0000;
      wstrb_q   <= 4'h0;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_have_q <= 1'b1;
        awaddr_q  <= s_axi_awaddr;
      end
      else if (wr_fire)
        aw_have_q <= 1'b0;
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_have_q <= 1'b1;
        wdata_q  <= s_axi_wdata;
        wstrb_q  <= s_axi_wstrb;
      end
      else if (wr_fire)
        w_have_q <= 1'b0;
    end
  end

  always_ff @(posedge mclk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      bvalid_q <= 1'b0;
      bresp_q  <= RESP_OKAY;
    end
    else if (wr_fire)
    begin
      bvalid_q <= 1'b1;
      bresp_q  <= mapped(awaddr_q) ? RESP_OKAY : RESP_SLVERR;
    end
    else if (s_axi_bready)
      bvalid_q <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Software-written configuration
  assign level_raise = wr_fire && (awaddr_q == OFS_CORE_LEVEL) && wstrb_q[0] && (wdata_q[1:0] > level_q);

  always_ff @(posedge mclk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      supv_q  <= SUPV_RESET;
      div_q   <= DIV_RESET;
      req_q   <= REQ_RESET;
      level_q <= LEVEL_RESET;
      freq_q  <= FREQ_RESET;
    end
    else if (wr_fire)
    begin
      if (awaddr_q == OFS_SUPV_CTRL && wstrb_q[0])
        supv_q <= wdata_q[3:0];
      if (awaddr_q == OFS_CLK_DIV && wstrb_q[0])
        div_q <= wdata_q[2:0];
      if (awaddr_q == OFS_CLK_REQ && wstrb_q[0])
        req_q <= wdata_q[1:0];
      if (awaddr_q == OFS_CORE_LEVEL && wstrb_q[0])
        level_q <= wdata_q[1:0];
      if (awaddr_q == OFS_OSC_FREQ)
      begin
        if (wstrb_q[0])
          freq_q[7:0] <= wdata_q[7:0];
        if (wstrb_q[1])
          freq_q[15:8] <= wdata_q[15:8];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Wake sequencer and execution hold-off
  assign short_mask = (!supv_q[SUP_EN_BIT] && !supv_q[MON_EN_BIT]) ||
                      (supv_q[SUP_EN_BIT] && supv_q[SUP_FP_BIT] &&
                       supv_q[MON_EN_BIT] && supv_q[MON_FP_BIT]);
  assign hold_load  = short_mask ? CNT_W'(HOLD_SHORT_CYC) : CNT_W'(HOLD_NORMAL_CYCLES);

  always_ff @(posedge mclk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      state_q <= ST_RUN;
    else
      unique case (state_q)
        ST_RUN:   if (sleep_enter_i) state_q <= ST_SLEEP;
        ST_SLEEP: if (wake_i) state_q <= ST_HOLD;
        ST_HOLD:  if (hold_done) state_q <= ST_RUN;
        default:  state_q <= ST_RUN;
      endcase
  end

  lsw_timer u_hold (
    .mclk_i   (mclk_i),
    .resetn_i (resetn_i),
    .load_i   ((state_q == ST_SLEEP) && wake_i),
    .value_i  (hold_load),
    .busy_o   (hold_busy),
    .done_o   (hold_done)
  );

  lsw_timer u_overshoot (
    .mclk_i   (mclk_i),
    .resetn_i (resetn_i),
    .load_i   ((state_q == ST_SLEEP) && wake_i),
    .value_i  (CNT_W'(OVERSHOOT_CYC)),
    .busy_o   (ovs_busy),
    .done_o   ()
  );

  assign cpu_clk_en_o    = (state_q == ST_RUN);
  assign osc_overshoot_o = ovs_busy;
  // Peripheral clock keeps running through the hold-off; only gated while asleep without request
  assign periph_clk_en_o = (state_q != ST_SLEEP) || req_q[REQ_EN_BIT];
  assign periph_src_xt2_o     = req_q[SRC_XT2_BIT];
  assign main_clock_divider_o = div_q;
  assign core_level_o         = level_q;

  always_comb
  begin
    unique case (level_q)
      2'h0: thr_khz = THR_L0_KHZ;
      2'h1: thr_khz = THR_L1_KHZ;
      2'h2: thr_khz = THR_L2_KHZ;
      2'h3: thr_khz = THR_L3_KHZ;
    endcase
  end

  // CPU sees an out-of-spec clock once released while the oscillator still overshoots
  assign overspeed = short_mask && ovs_busy && cpu_clk_en_o && mclk_from_osc_i &&
                     (freq_q > thr_khz) && (div_q != DIV_BY_TWO);

  ////////////////////////////////////////////////////////////////////////////
  // Supervisor settling delay after a core level raise
  assign set_load = supv_q[SUP_FP_BIT] ? CNT_W'(SETTLE_FP_CYC) : CNT_W'(SETTLE_NORM_CYCLES);

  lsw_timer u_settle (
    .mclk_i   (mclk_i),
    .resetn_i (resetn_i),
    .load_i   (level_raise),
    .value_i  (set_load),
    .busy_o   (set_busy),
    .done_o   (set_done)
  );

  always_ff @(posedge mclk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      reset_pulse_q <= 1'b0;
    else
      reset_pulse_q <= set_done && !vcore_settled_i;
  end

  assign supv_reset_o = reset_pulse_q;

  // Sticky reset cause; a new event wins over a write-one clear
  always_ff @(posedge mclk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      rst_evt_q <= 1'b0;
    else if (set_done && !vcore_settled_i)
      rst_evt_q <= 1'b1;
    else if (wr_fire && awaddr_q == OFS_STATUS && wstrb_q[0] && wdata_q[ST_RST_BIT])
      rst_evt_q <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite read path
  always_comb
  begin
    status = 32'h0000_0000;
    status[ST_HOLD_BIT] = hold_busy;
    status[ST_OVS_BIT]  = ovs_busy;
    status[ST_SET_BIT]  = set_busy;
    status[ST_EXP_BIT]  = overspeed;
    status[ST_RST_BIT]  = rst_evt_q;
  end

  assign s_axi_arready = !rvalid_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rdata   = rdata_q;
  assign s_axi_rresp   = rresp_q;

  always_ff @(posedge mclk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      rvalid_q <= 1'b0;
      rdata_q  <= 32'h0000_0000;
      rresp_q  <= RESP_OKAY;
    end
    else if (s_axi_arvalid && !rvalid_q)
    begin
      rvalid_q <= 1'b1;
      rresp_q  <= mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
      unique case (s_axi_araddr)
        OFS_SUPV_CTRL:  rdata_q <= {28'h0, supv_q};
        OFS_CLK_DIV:    rdata_q <= {29'h0, div_q};
        OFS_CLK_REQ:    rdata_q <= {30'h0, req_q};
        OFS_CORE_LEVEL: rdata_q <= {30'h0, level_q};
        OFS_OSC_FREQ:   rdata_q <= {16'h0, freq_q};
        OFS_STATUS:     rdata_q <= status;
        default:        rdata_q <= 32'h0000_0000;
      endcase
    end
    else if (s_axi_rready)
      rvalid_q <= 1'b0;
  end

endmodule : lsw_wake_ctrl

//--- verification/lsw_wake_props.sv
`timescale 1ns/100ps
module lsw_wake_props
  import lsw_pkg::*;
#(
  parameter int HOLD_NORMAL_CYCLES = 50
)
(
  // Clock and reset
  input wire logic        mclk_i,
  input wire logic        resetn_i,
  // Bus
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_arready,
  // Power
  input wire logic        sleep_enter_i,
  input wire logic        cpu_clk_en_o,
  input wire logic        periph_clk_en_o,
  input wire logic        osc_overshoot_o,
  input wire logic        supv_reset_o
);
  localparam int HL = HOLD_NORMAL_CYCLES - 3;
  localparam int HH = HOLD_NORMAL_CYCLES + 3;
  localparam int SL = HOLD_SHORT_CYC - 3;
  localparam int SH = HOLD_SHORT_CYC + 3;
  localparam int OL = OVERSHOOT_CYC - 3;
  localparam int OH = OVERSHOOT_CYC + 3;
  logic [15:0] hold_q;
  logic [15:0] ovs_q;
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!resetn_i);
  ////////////////////////////////////////////////////////////
  // Hold-off and overshoot lengths
  always_ff @(posedge mclk_i or negedge resetn_i)
  begin
    if (!resetn_i) hold_q <= '0;
    else if (cpu_clk_en_o) hold_q <= '0;
    else if (osc_overshoot_o || hold_q != '0) hold_q <= hold_q + 16'h0001;
  end
  always_ff @(posedge mclk_i or negedge resetn_i)
  begin
    if (!resetn_i) ovs_q <= '0;
    else if (!osc_overshoot_o) ovs_q <= '0;
    else ovs_q <= ovs_q + 16'h0001;
  end
  ////////////////////////////////////////////////////////////
  cpu_gate_a: assert property (sleep_enter_i && cpu_clk_en_o |=> !cpu_clk_en_o)
    else $error("cpu clock not gated at sleep");
  hold_len_a: assert property ($rose(cpu_clk_en_o) |-> hold_q inside {[HL:HH], [SL:SH]})
    else $error("hold-off length wrong");
  periph_on_a: assert property (osc_overshoot_o |-> periph_clk_en_o)
    else $error("peripheral clock gated in wake");
  ovs_start_a: assert property ($rose(osc_overshoot_o) |-> !cpu_clk_en_o)
    else $error("overshoot outside wake");
  ovs_len_a: assert property ($fell(osc_overshoot_o) |-> ovs_q inside {[OL:OH]})
    else $error("overshoot length wrong");
  rst_pulse_a: assert property (supv_reset_o |=> !supv_reset_o)
    else $error("reset pulse too long");
  b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while busy");
  cover property ($rose(cpu_clk_en_o));
  cover property (supv_reset_o);
  cover property ($fell(osc_overshoot_o));
endmodule : lsw_wake_props

//--- verification/tb.sv
`timescale 1ns/100ps
`define CK(a, b) begin n_tests++; if ((a) !== (b)) begin bad_count++; $display("[ERR] %0t mismatch", $time); end end
module tb
  import lsw_pkg::*;
;
  localparam int HN = 50;
  logic mclk_i, resetn_i;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd_q;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, br_q, rr_q, core_level_o;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready, sleep_enter_i, wake_i;
  logic mclk_from_osc_i, vcore_settled_i, cpu_clk_en_o, periph_clk_en_o;
  logic periph_src_xt2_o, osc_overshoot_o, supv_reset_o;
  logic [2:0] main_clock_divider_o;
  logic [15:0] x;
  logic req_m;
  int bad_count, n_tests, n, rv[6];
  lsw_wake_ctrl #(.HOLD_NORMAL_CYCLES(HN), .SETTLE_NORM_CYCLES(HN)) dut_u (.*);
  initial
  begin
    mclk_i = 0;
    forever #5 mclk_i = ~mclk_i;
  end
  function automatic logic [15:0] lf(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lf
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : print_verdict
  task automatic tmo();
    bad_count++;
    print_verdict();
  endtask : tmo
  ////////////////////////////////////////////////////////////
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int i;
    logic ta, tw, tb_;
    @(posedge mclk_i);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    for (i = 0; i < 50; i++)
    begin
      @(negedge mclk_i);
      ta = s_axi_awvalid && s_axi_awready;
      tw = s_axi_wvalid && s_axi_wready;
      tb_ = s_axi_bvalid;
      br_q = s_axi_bresp;
      @(posedge mclk_i);
      if (ta) s_axi_awvalid <= 0;
      if (tw) s_axi_wvalid <= 0;
      if (tb_) break;
    end
    s_axi_bready <= 0;
    if (i == 50) tmo();
  endtask : wr
  task automatic rd(input logic [7:0] a);
    int i;
    logic ta, tr;
    @(posedge mclk_i);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    for (i = 0; i < 50; i++)
    begin
      @(negedge mclk_i);
      ta = s_axi_arvalid && s_axi_arready;
      tr = s_axi_rvalid;
      rd_q = s_axi_rdata;
      rr_q = s_axi_rresp;
      @(posedge mclk_i);
      if (ta) s_axi_arvalid <= 0;
      if (tr) break;
    end
    s_axi_rready <= 0;
    if (i == 50) tmo();
  endtask : rd
  task automatic wake(input logic [3:0] s, input logic ex);
    int e;
    logic pe;
    wr(OFS_SUPV_CTRL, {28'h0, s});
    e = ((!s[SUP_EN_BIT] && !s[MON_EN_BIT]) || s == 4'hF) ? HOLD_SHORT_CYC : HN;
    @(posedge mclk_i) sleep_enter_i <= 1;
    @(posedge mclk_i) sleep_enter_i <= 0;
    @(negedge mclk_i) `CK(cpu_clk_en_o, 1'b0)
    `CK(periph_clk_en_o, req_m)
    @(posedge mclk_i) wake_i <= 1;
    @(posedge mclk_i) wake_i <= 0;
    pe = 1;
    for (n = 0; cpu_clk_en_o !== 1'b1 && n < 2000; n++)
    begin
      @(negedge mclk_i);
      pe &= periph_clk_en_o & osc_overshoot_o;
    end
    `CK(n >= e - 3 && n <= e + 3, 1'b1)
    `CK(pe, 1'b1)
    rd(OFS_STATUS);
    `CK(rd_q[ST_EXP_BIT], ex)
    `CK(rd_q[ST_OVS_BIT], 1'b1)
    for (n = 0; osc_overshoot_o !== 1'b0; n++)
    begin
      if (n == 1000) tmo();
      @(negedge mclk_i);
    end
    $display("wake test %0h done", s);
  endtask : wake
  ////////////////////////////////////////////////////////////
  initial
  begin
    {resetn_i, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = 0;
    {s_axi_rready, sleep_enter_i, wake_i, vcore_settled_i} = 0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 0;
    s_axi_wstrb = 4'hF;
    mclk_from_osc_i = 1;
    x = 16'h0034;
    rv = '{5, 0, 1, 0, 0, 0};
    repeat (3) @(posedge mclk_i);
    resetn_i <= 1;
    for (int i = 0; i < 6; i++)
    begin
      rd(8'(i * 4));
      `CK(rd_q, 32'(rv[i]))
    end
    rd(8'h18);
    `CK(rr_q, RESP_SLVERR)
    wr(8'h18, 32'h1);
    `CK(br_q, RESP_SLVERR)
    x = lf(x);
    wr(OFS_OSC_FREQ, {16'h0, x});
    rd(OFS_OSC_FREQ);
    `CK(rd_q, {16'h0, x})
    wr(OFS_CLK_DIV, 32'(DIV_BY_TWO));
    @(negedge mclk_i) `CK(main_clock_divider_o, DIV_BY_TWO)
    wr(OFS_CLK_REQ, 32'h3);
    req_m = 1'b1;
    @(negedge mclk_i) `CK(periph_src_xt2_o, 1'b1)
    $display("register test done");
    wake(4'h5, 1'b0);
    wake(4'h0, 1'b0);
    wake(4'hF, 1'b0);
    wake(4'hA, 1'b0);
    wake(4'h7, 1'b0);
    repeat (2)
    begin
      x = lf(x);
      wake(x[3:0], 1'b0);
    end
    // Divider back to full speed only after the level 0 wait
    repeat (32) @(posedge mclk_i);
    wr(OFS_CLK_DIV, 32'h0);
    @(negedge mclk_i) `CK(main_clock_divider_o, 3'h0)
    wr(OFS_CLK_REQ, 32'h0);
    req_m = 1'b0;
    // 8192 kHz is above the level 0 limit, so a short mask exposes the CPU
    wr(OFS_OSC_FREQ, 32'h2000);
    wake(4'h0, 1'b1);
    @(posedge mclk_i) mclk_from_osc_i <= 1'b0;
    wake(4'h0, 1'b0);
    $display("exposure test done");
    wr(OFS_SUPV_CTRL, 32'hF);
    wr(OFS_CORE_LEVEL, 32'h1);
    for (n = 0; supv_reset_o !== 1'b1 && n < 1000; n++) @(negedge mclk_i);
    `CK(n >= SETTLE_FP_CYC - 5 && n <= SETTLE_FP_CYC + 5, 1'b1)
    rd(OFS_STATUS);
    `CK(rd_q[ST_RST_BIT], 1'b1)
    wr(OFS_STATUS, 32'h10);
    rd(OFS_STATUS);
    `CK(rd_q[ST_RST_BIT], 1'b0)
    wr(OFS_SUPV_CTRL, 32'h5);
    wr(OFS_CORE_LEVEL, 32'h2);
    @(negedge mclk_i) `CK(core_level_o, 2'h2)
    repeat (10) @(posedge mclk_i);
    vcore_settled_i <= 1;
    repeat (HN + 20) @(negedge mclk_i);
    rd(OFS_STATUS);
    `CK(rd_q[ST_RST_BIT], 1'b0)
    $display("level test done");
    print_verdict();
  end
endmodule : tb
bind lsw_wake_ctrl lsw_wake_props #(.HOLD_NORMAL_CYCLES(HOLD_NORMAL_CYCLES)) chk_u (
  .mclk_i(mclk_i), .resetn_i(resetn_i), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_bresp(s_axi_bresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .s_axi_rdata(s_axi_rdata), .s_axi_arready(s_axi_arready), .sleep_enter_i(sleep_enter_i),
  .cpu_clk_en_o(cpu_clk_en_o), .periph_clk_en_o(periph_clk_en_o),
  .osc_overshoot_o(osc_overshoot_o), .supv_reset_o(supv_reset_o));
